// ===== rtl/serial_rx_pkg.sv
package serial_rx_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RX_STATUS_CTRL = 8'h18;
  localparam logic [7:0] OFS_RX_DATA = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_BAUD_DIV = 8'h28;

  // ----------------------------------------------------------------
  // Field positions of receive_status_control
  // ----------------------------------------------------------------
  localparam int BIT_PORT_EN = 7;
  localparam int BIT_NINE_SEL = 6;
  localparam int BIT_SINGLE_RX = 5;
  localparam int BIT_CONT_RX = 4;
  localparam int BIT_ADDR_DET = 3;
  localparam int BIT_FRAME_ERR = 2;
  localparam int BIT_OVR_ERR = 1;
  localparam int BIT_NINTH = 0;

  // Interrupt status bits
  localparam int IRQ_RXDONE = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_FRAMING = 2;
  localparam int IRQ_W = 3;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [4:0] RST_CTRL = 5'h00;
  localparam logic [2:0] RST_IMASK = 3'h0;
  localparam int CLK_HZ = 25000000;
  localparam int BAUD_DEFAULT = 9600;
  localparam int OVERSAMPLE = 16;
  localparam logic [15:0] RST_DIV = 16'(CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE) - 1);
  localparam logic [3:0] MID_TICK = 4'h8;
  localparam logic [3:0] START_PHASE = 4'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } rx_state_t;
endpackage

// ===== rtl/rx_tick_gen.sv
`timescale 1ns/100ps
module rx_tick_gen
  import serial_rx_pkg::*;
#(
  parameter int DIV_W = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DIV_W-1:0] divisor,
  input wire logic restart,
  output logic tick
);
  initial
  begin
    if (DIV_W < 2 || DIV_W > 16)
      $error("rx_tick_gen: DIV_W out of range");
  end

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;

  // --------------------------------------------------------------
  // Oversampling tick divider
  // --------------------------------------------------------------
  // Restart realigns the phase when the divisor changes
  always_comb
  begin
    tick = (cnt_r >= divisor);
    if (restart || tick)
      cnt_nxt = '0;
    else
      cnt_nxt = cnt_r + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end
endmodule

// ===== rtl/rx_majority_vote.sv
`timescale 1ns/100ps
module rx_majority_vote
  import serial_rx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic rx_in,
  output logic voted
);
  logic [2:0] hist_r;
  logic [2:0] hist_nxt;

  // --------------------------------------------------------------
  // Three-sample history and vote
  // --------------------------------------------------------------
  // Idle line is high, so history resets to ones
  always_comb
  begin
    hist_nxt = tick ? {hist_r[1:0], rx_in} : hist_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hist_r <= 3'h7;
    else
      hist_r <= hist_nxt;
  end

  // Two of three decides the level
  assign voted = (hist_r[0] & hist_r[1]) | (hist_r[1] & hist_r[2]) | (hist_r[0] & hist_r[2]); // [R6]

  a_vote_majority: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && hist_r[1:0] == 2'b11) |=> voted) // [R6]
    else $error("two high samples did not vote high");
endmodule

// ===== rtl/serial_receive_control.sv
`timescale 1ns/100ps
// Summary of operation
// R1: Asynchronous reception runs word after word while continuous receive is set; the receiver stays idle while overrun is set.
// R2: With address detect in nine-bit mode, only ninth-bit-one words load and interrupt; a ninth-bit-zero word with buffer full still sets overrun.
// R3: Without address detect every word loads; ninth bit is plain data.
// R4: Address filtering applies only to asynchronous nine-bit reception.
// R5: Software enables the serial port and pin directions before pins work.
// R6: Each received bit is a majority vote of three pin samples.
// R7: Overrun sets when a word completes with buffer full; clears while continuous receive is cleared.
module serial_receive_control
  import serial_rx_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  output logic irq
);
  initial
  begin
    if (ADDR_W < 8)
      $error("serial_receive_control: ADDR_W below 8");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [4:0] ctrl_r, ctrl_nxt;
  logic frame_err_r, frame_err_nxt;
  logic ovr_err_r, ovr_err_nxt;
  logic ninth_r, ninth_nxt;
  logic [7:0] rbuf_r, rbuf_nxt;
  logic full_r, full_nxt;
  logic [IRQ_W-1:0] ist_r, ist_nxt;
  logic [IRQ_W-1:0] imask_r, imask_nxt;
  logic [15:0] div_r, div_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic snap_full_r, snap_full_nxt;
  rx_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [3:0] bitn_r, bitn_nxt;
  logic [8:0] sh_r, sh_nxt;
  logic port_en, nine_sel, cont_en, addr_det, run;
  logic tick, voted, rx_line, mid;
  logic setup, wr_done, rd_done, mapped;
  logic word_done, stop_bad, accept;
  logic [7:0] word_data;
  logic word_bit8;
  logic [3:0] last_bit;

  assign port_en = ctrl_r[BIT_PORT_EN-3];
  assign nine_sel = ctrl_r[BIT_NINE_SEL-3];
  assign cont_en = ctrl_r[BIT_CONT_RX-3];
  assign addr_det = ctrl_r[BIT_ADDR_DET-3];
  // Receiver runs only with port and continuous receive enabled
  assign run = port_en && cont_en; // [R1] [R5]
  // Pin is ignored (idle high) while the port is off
  assign rx_line = port_en ? rx_pin : 1'b1; // [R5]

  // ----------------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------------
  rx_tick_gen #(.DIV_W(16)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(div_r),
    .restart(wr_done && mapped && paddr[7:0] == OFS_BAUD_DIV),
    .tick(tick)
  );

  rx_majority_vote u_vote (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .rx_in(rx_line),
    .voted(voted)
  );

  // ----------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------
  assign mid = tick && cnt_r == MID_TICK;
  assign last_bit = nine_sel ? 4'h8 : 4'h7;
  assign word_done = state_r == ST_STOP && mid && run;
  assign stop_bad = !voted;
  // Eight-bit words are taken from the top of the shifter
  assign word_data = nine_sel ? sh_r[7:0] : sh_r[8:1];
  assign word_bit8 = nine_sel ? sh_r[8] : 1'b0;
  // Filter only in nine-bit asynchronous mode with address detect
  assign accept = !(nine_sel && addr_det && !word_bit8); // [R2] [R3] [R4]

  // Next state of the receiver; overrun halts it until re-enabled
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = tick ? cnt_r + 4'h1 : cnt_r;
    bitn_nxt = bitn_r;
    sh_nxt = sh_r;
    if (!run || ovr_err_r)
    begin
      state_nxt = ST_IDLE; // [R1]
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (tick && !voted)
          begin
            state_nxt = ST_START;
            cnt_nxt = START_PHASE;
          end
        end
        ST_START:
        begin
          if (mid)
          begin
            state_nxt = voted ? ST_IDLE : ST_DATA;
            bitn_nxt = 4'h0;
          end
        end
        ST_DATA:
        begin
          if (mid)
          begin
            sh_nxt = {voted, sh_r[8:1]};
            bitn_nxt = bitn_r + 4'h1;
            if (bitn_r == last_bit)
              state_nxt = ST_STOP;
          end
        end
        ST_STOP:
        begin
          // Back to idle, ready for the next word at once
          if (mid)
            state_nxt = ST_IDLE; // [R1]
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      bitn_r <= 4'h0;
      sh_r <= 9'h000;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      bitn_r <= bitn_nxt;
      sh_r <= sh_nxt;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr_done = psel && penable && pwrite;
  assign rd_done = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign mapped = paddr[1:0] == 2'b00 && (paddr[ADDR_W-1:0] >> 2) <= (ADDR_W'(OFS_BAUD_DIV) >> 2)
                  && paddr[7:0] >= OFS_RX_STATUS_CTRL && paddr[ADDR_W-1:8] == '0;
  assign pslverr = psel && penable && !mapped;

  // Read data snapshot taken in the setup cycle
  always_comb
  begin
    prdata_nxt = prdata_r;
    snap_full_nxt = snap_full_r;
    if (setup && !pwrite)
    begin
      prdata_nxt = 32'h0000_0000;
      snap_full_nxt = 1'b0;
      if (mapped)
      begin
        unique case (paddr[7:0])
          OFS_RX_STATUS_CTRL: prdata_nxt[7:0] = {ctrl_r, frame_err_r, ovr_err_r, ninth_r};
          OFS_RX_DATA:
          begin
            prdata_nxt[8:0] = {ninth_r, rbuf_r};
            snap_full_nxt = full_r;
          end
          OFS_IRQ_STATUS: prdata_nxt[IRQ_W-1:0] = ist_r;
          OFS_IRQ_MASK: prdata_nxt[IRQ_W-1:0] = imask_r;
          OFS_BAUD_DIV: prdata_nxt[15:0] = div_r;
          default: prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers, buffer, flags and interrupts
  // ----------------------------------------------------------------
  // Hardware set wins over any same-cycle clear
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    imask_nxt = imask_r;
    div_nxt = div_r;
    rbuf_nxt = rbuf_r;
    ninth_nxt = ninth_r;
    frame_err_nxt = frame_err_r;
    full_nxt = full_r;
    ovr_err_nxt = ovr_err_r;
    ist_nxt = ist_r;
    // Unmapped writes are ignored
    if (wr_done && mapped)
    begin
      unique case (paddr[7:0])
        OFS_RX_STATUS_CTRL: ctrl_nxt = pwdata[7:3];
        OFS_IRQ_MASK: imask_nxt = pwdata[IRQ_W-1:0];
        OFS_BAUD_DIV: div_nxt = pwdata[15:0];
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    // Reading the buffer frees it; only if it was full when sampled
    if (rd_done && mapped && paddr[7:0] == OFS_RX_DATA && snap_full_r)
    begin
      full_nxt = 1'b0;
      frame_err_nxt = 1'b0;
    end
    // Read of interrupt status clears only the bits it returned
    if (rd_done && mapped && paddr[7:0] == OFS_IRQ_STATUS)
      ist_nxt = ist_r & ~prdata_r[IRQ_W-1:0];
    // Clearing continuous receive clears overrun
    if (!cont_en)
      ovr_err_nxt = 1'b0; // [R7]
    if (word_done)
    begin
      if (full_r)
      begin
        ovr_err_nxt = 1'b1; // [R7]
        ist_nxt[IRQ_OVERRUN] = 1'b1;
      end
      else if (accept)
      begin
        // Load word, ninth bit and framing status together
        rbuf_nxt = word_data; // [R2] [R3]
        ninth_nxt = word_bit8; // [R3]
        frame_err_nxt = stop_bad;
        full_nxt = 1'b1;
        ist_nxt[IRQ_RXDONE] = 1'b1; // [R2]
        if (stop_bad)
          ist_nxt[IRQ_FRAMING] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= RST_CTRL;
      imask_r <= RST_IMASK;
      div_r <= RST_DIV;
      rbuf_r <= 8'h00;
      ninth_r <= 1'b0;
      frame_err_r <= 1'b0;
      full_r <= 1'b0;
      ovr_err_r <= 1'b0;
      ist_r <= '0;
      prdata_r <= 32'h0000_0000;
      snap_full_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      imask_r <= imask_nxt;
      div_r <= div_nxt;
      rbuf_r <= rbuf_nxt;
      ninth_r <= ninth_nxt;
      frame_err_r <= frame_err_nxt;
      full_r <= full_nxt;
      ovr_err_r <= ovr_err_nxt;
      ist_r <= ist_nxt;
      prdata_r <= prdata_nxt;
      snap_full_r <= snap_full_nxt;
    end
  end

  // Level interrupt from unmasked sticky bits
  assign irq = |(ist_r & imask_r);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_disabled_goes_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !cont_en |=> state_r == ST_IDLE) // [R1]
    else $error("receiver active with continuous receive off");
  a_port_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (!port_en)[*2] |-> state_r == ST_IDLE) // [R5]
    else $error("receiver active with serial port off");
  a_addr_filter_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (word_done && nine_sel && addr_det && !sh_r[8] && !full_r) |=> !full_r && !ist_r[IRQ_RXDONE]
      || $past(ist_r[IRQ_RXDONE])) // [R2]
    else $error("data word loaded with address detect on");
  a_load_all_words: assert property (@(posedge pclk) disable iff (!presetn)
    (word_done && !addr_det && !full_r) |=> full_r && ninth_r == $past(word_bit8)) // [R3]
    else $error("word not loaded with address detect off");
  a_eight_bit_nofilter: assert property (@(posedge pclk) disable iff (!presetn)
    (word_done && !nine_sel && !full_r) |=> full_r && rbuf_r == $past(sh_r[8:1])) // [R4]
    else $error("eight-bit word filtered or misaligned");
  a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn)
    (word_done && full_r) |=> ovr_err_r) // [R7]
    else $error("overrun not flagged");
  a_overrun_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (ovr_err_r && cont_en) |=> ovr_err_r) // [R7]
    else $error("overrun cleared without continuous receive off");
  a_overrun_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (!cont_en ##1 !cont_en) |-> !ovr_err_r) // [R7]
    else $error("overrun stuck with continuous receive off");
  a_word_back_idle: assert property (@(posedge pclk) disable iff (!presetn)
    word_done |=> state_r == ST_IDLE ##1 state_r != ST_STOP) // [R1]
    else $error("receiver not ready for next word");

  c_word_loaded: cover property (@(posedge pclk) disable iff (!presetn)
    word_done && !full_r && accept);
  c_overrun: cover property (@(posedge pclk) disable iff (!presetn)
    word_done && full_r);
  c_addr_dropped: cover property (@(posedge pclk) disable iff (!presetn)
    word_done && !accept);
  c_framing: cover property (@(posedge pclk) disable iff (!presetn)
    word_done && stop_bad && accept);
endmodule

// ===== testbench/serial_tx_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Remote asynchronous transmitter driving the receive line
// ----------------------------------------------------------------
module serial_tx_model
#(
  parameter int BIT_CLKS = 32
)
(
  input wire logic pclk,
  output logic line
);
  // Line idles high between frames
  initial line = 1'b1;

  // Start bit, data bits LSB first, one stop bit, then idle high
  task automatic send(input logic [8:0] w, input int nb, input bit glitch);
    logic b;
    for (int i = 0; i < nb + 2; i++)
    begin
      b = (i == 0) ? 1'b0 : (i == nb + 1) ? 1'b1 : w[i-1];
      for (int c = 0; c < BIT_CLKS; c++)
      begin
        @(posedge pclk);
        line <= (glitch && c == 12) ? ~b : b; // One-clock spike inside each bit
      end
    end
  endtask

  // Eight data bits with a stop bit held low past its middle, then idle
  task automatic send_bad_stop(input logic [7:0] w);
    for (int i = 0; i < 10; i++)
      for (int c = 0; c < BIT_CLKS; c++)
      begin
        @(posedge pclk);
        line <= (i == 0) ? 1'b0 : (i == 9) ? (c >= 24) : w[i-1];
      end
    repeat (BIT_CLKS) @(posedge pclk);
  endtask
endmodule

// ===== testbench/serial_receive_control_bench.sv
`timescale 1ns/100ps
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t %s", $time, m); end end
// ----------------------------------------------------------------
// Self-checking bench for the receive control block
// ----------------------------------------------------------------
module serial_receive_control_bench;
  import serial_rx_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_pin;
  logic irq;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;

  // Clock, 40 ns period
  always #20 pclk = ~pclk;

  serial_receive_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .irq(irq));
  serial_tx_model #(.BIT_CLKS(32)) tx (.pclk(pclk), .line(rx_pin));

  // Verdict and end of run
  task automatic report_and_stop();
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // One APB transfer: setup, access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Send a word, then check irq, status and buffer contents
  task automatic rx_check(input logic [8:0] w, input int nb, input bit g,
                          input logic [2:0] st);
    logic [8:0] msk;
    msk = (nb == 9) ? 9'h1ff : 9'h0ff;
    tx.send(w, nb, g);
    `CHK(irq, |st, "irq level")
    apb(1'b0, 12'h020, 32'h0);
    `CHK(rd[2:0], st, "irq status")
    @(negedge pclk);
    `CHK(irq, 1'b0, "irq after clear")
    if (st[0])
    begin
      apb(1'b0, 12'h01c, 32'h0);
      `CHK(rd[8:0] & msk, w & msk, "received word")
    end
  endtask

  task automatic t_reset();
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd[7:1], 7'h00, "control reset")
    `CHK(irq, 1'b0, "irq reset")
    apb(1'b1, 12'h028, 32'h1);
    apb(1'b1, 12'h024, 32'h7);
    apb(1'b1, 12'h018, 32'h90);
  endtask

  task automatic t_stream();
    rx_check(9'h0a5, 8, 1'b0, 3'h1);
    rx_check(9'h05a, 8, 1'b1, 3'h1);
  endtask

  task automatic t_nine();
    apb(1'b1, 12'h018, 32'hd0);
    rx_check(9'h13c, 9, 1'b0, 3'h1);
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd[0], 1'b1, "ninth bit flag")
    apb(1'b1, 12'h018, 32'hd8);
    rx_check(9'h042, 9, 1'b0, 3'h0);
    rx_check(9'h155, 9, 1'b0, 3'h1);
    apb(1'b1, 12'h018, 32'h98);
    rx_check(9'h033, 8, 1'b0, 3'h1);
  endtask

  task automatic t_overrun();
    apb(1'b1, 12'h018, 32'h90);
    tx.send(9'h011, 8, 1'b0);
    tx.send(9'h022, 8, 1'b0);
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd[1], 1'b1, "overrun set")
    rx_check(9'h011, 8, 1'b0, 3'h3);
    apb(1'b1, 12'h018, 32'h80);
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd[1], 1'b0, "overrun cleared")
    tx.send(9'h077, 8, 1'b0);
    apb(1'b0, 12'h020, 32'h0);
    `CHK(rd[2:0], 3'h0, "no receive when disabled")
    apb(1'b1, 12'h018, 32'h90);
    rx_check(9'h066, 8, 1'b0, 3'h1);
  endtask

  // Low stop bit: word loads with framing flag, freed by buffer read
  task automatic t_frame();
    tx.send_bad_stop(8'h3c);
    `CHK(irq, 1'b1, "framing irq")
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd[2], 1'b1, "framing flag set")
    apb(1'b0, 12'h020, 32'h0);
    `CHK(rd[2:0], 3'h5, "framing status")
    apb(1'b0, 12'h01c, 32'h0);
    `CHK(rd[7:0], 8'h3c, "framed word")
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd[2], 1'b0, "framing flag cleared")
  endtask

  task automatic t_mask();
    apb(1'b1, 12'h024, 32'h0);
    tx.send(9'h00f, 8, 1'b0);
    `CHK(irq, 1'b0, "masked irq")
    apb(1'b0, 12'h020, 32'h0);
    `CHK(rd[2:0], 3'h1, "masked status")
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK(err, 1'b1, "unmapped error")
    `CHK(rd, 32'h0, "unmapped data")
  endtask

  // Reset for 8 cycles, then the scenarios
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_stream();
    t_nine();
    t_overrun();
    t_frame();
    t_mask();
    report_and_stop();
  end
endmodule
